// File: verilog/esr_record_asm.v
// event sample record assembler: basic group tail and memory group
//
// Behaviour
// - ip word is retired trigger instruction pointer
// - counter mask word marks every triggering counter
// - timestamp captured when record is generated
// - legacy address word sign-extended canonical
// - legacy aux: load source, or store status
// - legacy latency: load service cycles
// - tx word: region cycles low, abort high
// - updated address canonical, zero if unknown
// - bits 3:0 source, zero when unknown
// - bit 4 second translation buffer miss
// - bit 5 locked atomic access
// - bit 6 store forwarding data block
// - bit 7 store address conflict block
// - bits 15:0 dispatch-to-completion latency
// - bits 47:32 cache access-to-return latency
// - store cache latency: l1 write to done
// - word 0 format and size, groups packed
`default_nettype none
`include "esr_regs.vh"
module esr_record_asm (
  input  wire        core_clk,
  input  wire        rst,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // sample trigger and captured fields
  input  wire        sampleTrig,
  input  wire        adaptiveRec,
  input  wire [63:0] triggerInstrPointer,
  input  wire [63:0] trigCounterMask,
  input  wire [47:0] accessLinearAddr,
  input  wire        addrKnown,
  input  wire [3:0]  dataSource,
  input  wire        sourceKnown,
  input  wire        secondXlatMissFlag,
  input  wire        atomicAccessFlag,
  input  wire        dataBlocked,
  input  wire        addrBlocked,
  input  wire        isStore,
  input  wire [63:0] storeStatus,
  input  wire        memoryRetireEvent,
  // latency events from the load/store pipeline
  input  wire        loadDispatch,
  input  wire        instrComplete,
  input  wire        cacheStart,
  input  wire        cacheDone,
  // transactional region events
  input  wire        txBegin,
  input  wire        txEnd,
  input  wire [31:0] txAbortInfo,
  // record word stream
  output reg  [63:0] recWord,
  output reg         recValid,
  output reg         recLast,
  input  wire        recReady
);
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function [63:0] canon;
    input [47:0] va;
    begin
      canon = {{16{va[`ESR_VA_MSB]}}, va};
    end
  endfunction

  function [31:0] satInc;
    input [31:0] v;
    input [31:0] maxV;
    begin
      satInc = (v == maxV) ? v : v + 32'h0000_0001;
    end
  endfunction

  // -----------------------------------------------------------------
  // register file over axi4-lite
  // -----------------------------------------------------------------
  reg  [31:0] ctrl_r;
  reg  [47:0] fmtCfg_r;
  reg  [15:0] recCount_r;
  reg  [31:0] dropCount_r;
  reg  [7:0]  awAddr_r;
  reg         awHeld_r;
  reg  [31:0] wData_r;
  reg  [3:0]  wStrb_r;
  reg         wHeld_r;
  reg  [1:0]  state_r;
  wire        busy = (state_r != `ESR_ST_IDLE);
  wire        wrGo = awHeld_r && wHeld_r && !s_axi_bvalid;

  function [31:0] mergeStrb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      k;
    begin
      mergeStrb = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          mergeStrb[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  // upper format half merged through a full word, only its low half is kept
  wire [31:0] fmtHiMrg = mergeStrb({16'h0000, fmtCfg_r[`ESR_FMT_W-1:32]}, wData_r, wStrb_r);

  always @(posedge core_clk) begin
    if (rst) begin
      ctrl_r        <= `ESR_CTRL_RST;
      fmtCfg_r      <= `ESR_FMT_RST;
      awAddr_r      <= 8'h00;
      awHeld_r      <= 1'b0;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
      wHeld_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ESR_RESP_OKAY;
    end else begin
      // address and data are taken independently, in either order
      s_axi_awready <= !awHeld_r && !s_axi_awready;
      s_axi_wready  <= !wHeld_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wrGo) begin
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ESR_RESP_OKAY;
        case (awAddr_r)
          `ESR_OFF_CTRL: begin
            ctrl_r <= mergeStrb(ctrl_r, wData_r, wStrb_r);
          end
          `ESR_OFF_FMT_LO: begin
            fmtCfg_r[31:0] <= mergeStrb(fmtCfg_r[31:0], wData_r, wStrb_r);
          end
          `ESR_OFF_FMT_HI: begin
            fmtCfg_r[`ESR_FMT_W-1:32] <= fmtHiMrg[`ESR_FMT_HI_W-1:0];
          end
          `ESR_OFF_STATUS, `ESR_OFF_DROP: begin
          end
          default: begin
            s_axi_bresp <= `ESR_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `ESR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ESR_RESP_OKAY;
        case (s_axi_araddr)
          `ESR_OFF_CTRL:   s_axi_rdata <= ctrl_r & 32'h0000_0003;
          `ESR_OFF_FMT_LO: s_axi_rdata <= fmtCfg_r[31:0];
          `ESR_OFF_FMT_HI: s_axi_rdata <= {16'h0000, fmtCfg_r[`ESR_FMT_W-1:32]};
          `ESR_OFF_STATUS: s_axi_rdata <= {recCount_r, 15'h0000, busy};
          `ESR_OFF_DROP:   s_axi_rdata <= dropCount_r;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ESR_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // timestamp and latency measurement
  // -----------------------------------------------------------------
  reg  [63:0] tsCount_r;
  reg  [15:0] instrRun_r;
  reg  [15:0] instrLat_r;
  reg         instrOn_r;
  reg  [15:0] cacheRun_r;
  reg  [15:0] cacheLat_r;
  reg         cacheOn_r;
  reg  [31:0] txRun_r;
  reg  [31:0] txCycles_r;
  reg  [31:0] txAbort_r;
  reg         txOn_r;
  wire [31:0] instrRunInc = satInc({16'h0000, instrRun_r}, 32'h0000_FFFF);
  wire [31:0] cacheRunInc = satInc({16'h0000, cacheRun_r}, 32'h0000_FFFF);

  always @(posedge core_clk) begin
    if (rst) begin
      tsCount_r  <= 64'h0000_0000_0000_0000;
      instrRun_r <= 16'h0000;
      instrLat_r <= 16'h0000;
      instrOn_r  <= 1'b0;
      cacheRun_r <= 16'h0000;
      cacheLat_r <= 16'h0000;
      cacheOn_r  <= 1'b0;
      txRun_r    <= 32'h0000_0000;
      txCycles_r <= 32'h0000_0000;
      txAbort_r  <= 32'h0000_0000;
      txOn_r     <= 1'b0;
    end else begin
      tsCount_r <= tsCount_r + 64'h0000_0000_0000_0001;
      // dispatch to completion, including dependency and lookup stalls
      if (loadDispatch) begin
        instrRun_r <= 16'h0001;
        instrOn_r  <= 1'b1;
      end else if (instrOn_r) begin
        instrRun_r <= instrRunInc[`ESR_LAT_W-1:0];
      end
      if (instrComplete && instrOn_r && !loadDispatch) begin
        instrLat_r <= instrRun_r;
        instrOn_r  <= 1'b0;
      end
      // the pipeline raises cacheStart at the cache access for loads and at the
      // l1 write for stores, and cacheDone at data return or line write done
      if (cacheStart) begin
        cacheRun_r <= 16'h0001;
        cacheOn_r  <= 1'b1;
      end else if (cacheOn_r) begin
        cacheRun_r <= cacheRunInc[`ESR_LAT_W-1:0];
      end
      if (cacheDone && cacheOn_r && !cacheStart) begin
        cacheLat_r <= cacheRun_r;
        cacheOn_r  <= 1'b0;
      end
      if (txBegin) begin
        txRun_r <= 32'h0000_0001;
        txOn_r  <= 1'b1;
      end else if (txOn_r) begin
        txRun_r <= satInc(txRun_r, 32'hFFFF_FFFF);
      end
      // abort or commit both close the region
      if (txEnd && txOn_r && !txBegin) begin
        txCycles_r <= txRun_r;
        txAbort_r  <= txAbortInfo;
        txOn_r     <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // snapshot at trigger
  // -----------------------------------------------------------------
  reg  [63:0] sHead_r;
  reg  [63:0] sIp_r;
  reg  [63:0] sMask_r;
  reg  [63:0] sTs_r;
  reg  [63:0] sAddr_r;
  reg  [63:0] sAux_r;
  reg  [63:0] sLat_r;
  reg  [63:0] sTx_r;
  reg  [2:0]  lastIdx_r;
  reg  [2:0]  idx_r;
  wire        memGrp = adaptiveRec && fmtCfg_r[`ESR_FMT_MEM];
  wire        updLay = ctrl_r[`ESR_CTRL_UPD];
  wire        take   = sampleTrig && ctrl_r[`ESR_CTRL_EN] && !busy;
  wire [47:0] fmtVal = adaptiveRec ? fmtCfg_r : `ESR_FMT_RST;
  wire [15:0] sizeB  = memGrp ? `ESR_SIZE_MEM : `ESR_SIZE_BASIC;
  wire [3:0]  srcEnc = sourceKnown ? dataSource : 4'h0;
  wire [63:0] legAux = !memoryRetireEvent ? 64'h0000_0000_0000_0000 :
                       isStore ? storeStatus : {60'h0, dataSource};
  wire [63:0] updAux = {56'h0, addrBlocked, dataBlocked, atomicAccessFlag,
                        secondXlatMissFlag, srcEnc};
  wire [63:0] legLat = memoryRetireEvent ? {48'h0, instrLat_r} : 64'h0000_0000_0000_0000;
  wire [63:0] updLat = {16'h0000, cacheLat_r, 16'h0000, instrLat_r};

  always @(posedge core_clk) begin
    if (rst) begin
      sHead_r   <= 64'h0000_0000_0000_0000;
      sIp_r     <= 64'h0000_0000_0000_0000;
      sMask_r   <= 64'h0000_0000_0000_0000;
      sTs_r     <= 64'h0000_0000_0000_0000;
      sAddr_r   <= 64'h0000_0000_0000_0000;
      sAux_r    <= 64'h0000_0000_0000_0000;
      sLat_r    <= 64'h0000_0000_0000_0000;
      sTx_r     <= 64'h0000_0000_0000_0000;
      lastIdx_r <= `ESR_LAST_BASIC;
    end else if (take) begin
      sHead_r   <= {sizeB, fmtVal};
      sIp_r     <= triggerInstrPointer;
      sMask_r   <= trigCounterMask;
      sTs_r     <= tsCount_r;
      sAddr_r   <= updLay ? (addrKnown ? canon(accessLinearAddr) : 64'h0000_0000_0000_0000)
                          : canon(accessLinearAddr);
      sAux_r    <= updLay ? updAux : legAux;
      sLat_r    <= updLay ? updLat : legLat;
      sTx_r     <= {txAbort_r, txCycles_r};
      lastIdx_r <= memGrp ? `ESR_LAST_MEM : `ESR_LAST_BASIC;
    end
  end

  reg [63:0] fillWord;
  always @* begin
    fillWord = sHead_r;
    case (idx_r)
      `ESR_W_FMT:  fillWord = sHead_r;
      `ESR_W_IP:   fillWord = sIp_r;
      `ESR_W_CNT:  fillWord = sMask_r;
      `ESR_W_TS:   fillWord = sTs_r;
      `ESR_W_ADDR: fillWord = sAddr_r;
      `ESR_W_AUX:  fillWord = sAux_r;
      `ESR_W_LAT:  fillWord = sLat_r;
      `ESR_W_TX:   fillWord = sTx_r;
      default:     fillWord = sHead_r;
    endcase
  end

  // -----------------------------------------------------------------
  // record sequencer: fill buffer, then stream words in order
  // -----------------------------------------------------------------
  wire [63:0] memRd;
  esr_word_mem i_esr_word_mem (
    .clk    (core_clk),
    .wrEn   (state_r == `ESR_ST_FILL),
    .wrAddr (idx_r),
    .wrData (fillWord),
    .rdAddr (idx_r),
    .rdData (memRd)
  );

  always @(posedge core_clk) begin
    if (rst) begin
      state_r     <= `ESR_ST_IDLE;
      idx_r       <= 3'h0;
      recWord     <= 64'h0000_0000_0000_0000;
      recValid    <= 1'b0;
      recLast     <= 1'b0;
      recCount_r  <= 16'h0000;
      dropCount_r <= 32'h0000_0000;
    end else begin
      // a trigger that finds the assembler busy is dropped and counted
      if (sampleTrig && ctrl_r[`ESR_CTRL_EN] && busy) begin
        dropCount_r <= satInc(dropCount_r, 32'hFFFF_FFFF);
      end
      case (state_r)
        `ESR_ST_IDLE: begin
          if (take) begin
            idx_r   <= 3'h0;
            state_r <= `ESR_ST_FILL;
          end
        end
        `ESR_ST_FILL: begin
          if (idx_r == lastIdx_r) begin
            idx_r   <= 3'h0;
            state_r <= `ESR_ST_RDREQ;
          end else begin
            idx_r <= idx_r + 3'h1;
          end
        end
        `ESR_ST_RDREQ: begin
          // one cycle for the registered buffer read
          state_r <= `ESR_ST_SEND;
        end
        `ESR_ST_SEND: begin
          if (!recValid) begin
            recWord  <= memRd;
            recValid <= 1'b1;
            recLast  <= (idx_r == lastIdx_r);
          end else if (recReady) begin
            recValid <= 1'b0;
            recLast  <= 1'b0;
            if (recLast) begin
              recCount_r <= recCount_r + 16'h0001;
              state_r    <= `ESR_ST_IDLE;
            end else begin
              idx_r   <= idx_r + 3'h1;
              state_r <= `ESR_ST_RDREQ;
            end
          end
        end
        default: begin
          state_r <= `ESR_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verilog/esr_regs.vh
// constants for the sample record field assembler
`ifndef ESR_REGS_VH
`define ESR_REGS_VH
// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define ESR_OFF_CTRL      8'h00
`define ESR_OFF_FMT_LO    8'h04
`define ESR_OFF_FMT_HI    8'h08
`define ESR_OFF_STATUS    8'h0C
`define ESR_OFF_DROP      8'h10
// -----------------------------------------------------------------
// control and format fields
// -----------------------------------------------------------------
`define ESR_CTRL_EN       0
`define ESR_CTRL_UPD      1
`define ESR_CTRL_RST      32'h0000_0000
`define ESR_FMT_MEM       0
`define ESR_FMT_W         48
`define ESR_FMT_HI_W      16
`define ESR_FMT_RST       48'h0000_0000_0000
// -----------------------------------------------------------------
// record layout, word indices and sizes
// -----------------------------------------------------------------
`define ESR_W_FMT         3'h0
`define ESR_W_IP          3'h1
`define ESR_W_CNT         3'h2
`define ESR_W_TS          3'h3
`define ESR_W_ADDR        3'h4
`define ESR_W_AUX         3'h5
`define ESR_W_LAT         3'h6
`define ESR_W_TX          3'h7
`define ESR_LAST_BASIC    3'h3
`define ESR_LAST_MEM      3'h7
`define ESR_SIZE_BASIC    16'h0020
`define ESR_SIZE_MEM      16'h0040
`define ESR_VA_MSB        47
`define ESR_SRC_W         4
`define ESR_LAT_W         16
`define ESR_TXC_W         32
// -----------------------------------------------------------------
// axi responses and record states
// -----------------------------------------------------------------
`define ESR_RESP_OKAY     2'h0
`define ESR_RESP_SLVERR   2'h2
`define ESR_ST_IDLE       2'h0
`define ESR_ST_FILL       2'h1
`define ESR_ST_RDREQ      2'h2
`define ESR_ST_SEND       2'h3
`endif

// File: verilog/esr_word_mem.v
// record word buffer, eight 64-bit words, registered read data
`default_nettype none
module esr_word_mem (
  input  wire        clk,
  input  wire        wrEn,
  input  wire [2:0]  wrAddr,
  input  wire [63:0] wrData,
  input  wire [2:0]  rdAddr,
  output reg  [63:0] rdData
);
  reg [63:0] mem [0:7];

  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule
`default_nettype wire

// File: tb/esr_record_asm_checker.sv
// checker for the record word stream and the register bus handshakes
`default_nettype none
module esr_record_asm_checker (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [63:0] recWord,
  input wire logic        recValid,
  input wire logic        recLast,
  input wire logic        recReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wordIdx_r;
  logic [2:0] lastIdx_r;
  wire  [2:0] lastCur;

  // -------------------------------------------------------------
  // word tracking
  // -------------------------------------------------------------
  // format bit 0 marks the memory group, so word 0 tells the record length
  assign lastCur = (wordIdx_r == 3'h0) ? (recWord[0] ? 3'h7 : 3'h3) : lastIdx_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wordIdx_r <= 3'h0;
      lastIdx_r <= 3'h3;
    end else if (recValid && recReady) begin
      wordIdx_r <= recLast ? 3'h0 : wordIdx_r + 3'h1;
      lastIdx_r <= lastCur;
    end
  end

  // -------------------------------------------------------------
  // properties
  // -------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence takeWord;
    recValid && recReady;
  endsequence
  sequence refill;
    !recValid ##[1:4] recValid;
  endsequence

  word_gap_a: assert property (takeWord ##0 !recLast |=> refill)
    else $error("next record word did not follow in time");
  last_gap_a: assert property (takeWord ##0 recLast |=> !recValid)
    else $error("word offered after the final record word");
  word_hold_a: assert property (recValid && !recReady |=> recValid && $stable(recWord) && $stable(recLast))
    else $error("record word changed before it was taken");
  fmt_size_a: assert property (recValid && wordIdx_r == 3'h0 |->
    recWord[63:48] == (recWord[0] ? 16'h0040 : 16'h0020))
    else $error("record size does not match the format word");
  last_word_a: assert property (recValid |-> recLast == (wordIdx_r == lastCur))
    else $error("final word flag at the wrong word");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !recValid && !s_axi_bvalid && !s_axi_rvalid)
    else $error("valid output after reset");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed early");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read data pending");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held beyond one cycle");
endmodule

bind esr_record_asm esr_record_asm_checker i_esr_record_asm_checker (.*);
`default_nettype wire

// File: tb/esr_record_asm_tb.sv
// self-checking bench for the record assembler
`default_nettype none
`include "esr_regs.vh"
module esr_record_asm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] FMT   = 48'h00B2_0000_0A01;
  localparam logic [47:0] ADDR  = 48'h8000_1234_5678;
  localparam logic [63:0] MASK  = 64'h0000_0001_0000_0004;
  localparam logic [63:0] STST  = 64'h0000_0000_0000_00C3;
  localparam logic [31:0] ABORT = 32'hDEAD_0001;
  localparam logic [3:0]  SRC   = 4'h9;
  logic        core_clk = 1'b0, rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, txAbortInfo = ABORT;
  logic [3:0]  s_axi_wstrb = 4'hF, dataSource = SRC;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        sampleTrig = 1'b0, adaptiveRec = 1'b0, addrKnown = 1'b0, sourceKnown = 1'b0, isStore = 1'b0;
  logic        secondXlatMissFlag = 1'b0, atomicAccessFlag = 1'b0, dataBlocked = 1'b0, addrBlocked = 1'b0;
  logic        memoryRetireEvent = 1'b0, recReady = 1'b0, loadDispatch = 1'b0, instrComplete = 1'b0;
  logic        cacheStart = 1'b0, cacheDone = 1'b0, txBegin = 1'b0, txEnd = 1'b0, recValid, recLast;
  logic [63:0] triggerInstrPointer = 64'h0, trigCounterMask = MASK, storeStatus = STST, recWord, tsM;
  logic [47:0] accessLinearAddr = ADDR;
  int          numErrors = 0;
  int          nChecks = 0;

  esr_record_asm i_esr_record_asm (.*);

  always #5 core_clk = ~core_clk;
  // free-running mirror of the timestamp, cleared by the same reset
  always @(posedge core_clk) tsM <= rst ? 64'h0 : tsM + 64'h1;

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    if (numErrors == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hung(input string nm);
    numErrors++;
    $display("[FAIL] %s expected answer seen timeout", nm);
    close_out();
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 40) hung("bvalid");
    chk("bresp", s_axi_bresp, er);
  endtask

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int i;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 40) hung("rvalid");
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
  endtask

  // latencies of 5, 3 and 7 cycles, then a two-cycle trigger whose second cycle hits a busy block
  task automatic run_rec(input logic upd, ad, st, kn, mre, input logic [3:0] f);
    logic [63:0] e [8];
    int          i, w, n;
    for (i = 0; i < 9; i++) begin
      loadDispatch  <= (i == 0);
      cacheStart    <= (i == 0);
      txBegin       <= (i == 0);
      cacheDone     <= (i == 3);
      instrComplete <= (i == 5);
      txEnd         <= (i == 7);
      @(posedge core_clk);
    end
    {addrBlocked, dataBlocked, atomicAccessFlag, secondXlatMissFlag} <= f;
    triggerInstrPointer <= {60'h00007FF0C0DE100, f};
    adaptiveRec         <= ad;
    isStore             <= st;
    addrKnown           <= kn;
    sourceKnown         <= kn;
    memoryRetireEvent   <= mre;
    sampleTrig          <= 1'b1;
    @(posedge core_clk);
    e[3] = tsM;
    @(posedge core_clk);
    sampleTrig <= 1'b0;
    n = ad ? 8 : 4;
    e[0] = ad ? {16'h0040, FMT} : {16'h0020, 48'h0};
    e[1] = {60'h00007FF0C0DE100, f};
    e[2] = MASK;
    e[4] = (upd && !kn) ? 64'h0 : {{16{ADDR[47]}}, ADDR};
    e[5] = upd ? {56'h0, f, kn ? SRC : 4'h0} : (!mre ? 64'h0 : (st ? STST : {60'h0, SRC}));
    e[6] = upd ? 64'h0000_0003_0000_0005 : (mre ? 64'h5 : 64'h0);
    e[7] = {ABORT, 32'h7};
    for (w = 0; w < n; w++) begin
      i = 0;
      do begin
        @(posedge core_clk);
        i++;
      end while (recValid !== 1'b1 && i < 40);
      if (recValid !== 1'b1) hung("recValid");
      recReady <= 1'b1;
      @(posedge core_clk);
      chk("recWord", recWord, e[w]);
      chk("recLast", recLast, w == n - 1);
      recReady <= 1'b0;
    end
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    axi_rd(`ESR_OFF_CTRL, 32'h0, `ESR_RESP_OKAY);
    axi_rd(`ESR_OFF_STATUS, 32'h0, `ESR_RESP_OKAY);
    axi_rd(8'h40, 32'h0, `ESR_RESP_SLVERR);
    axi_wr(8'h40, 32'hFFFF_FFFF, `ESR_RESP_SLVERR);
    axi_wr(`ESR_OFF_STATUS, 32'hFFFF_FFFF, `ESR_RESP_OKAY);
    axi_rd(`ESR_OFF_STATUS, 32'h0, `ESR_RESP_OKAY);
    axi_wr(`ESR_OFF_CTRL, 32'hFFFF_FFFF, `ESR_RESP_OKAY);
    axi_rd(`ESR_OFF_CTRL, 32'h3, `ESR_RESP_OKAY);
    axi_wr(`ESR_OFF_CTRL, 32'h1, `ESR_RESP_OKAY);
    axi_wr(`ESR_OFF_FMT_LO, FMT[31:0], `ESR_RESP_OKAY);
    axi_wr(`ESR_OFF_FMT_HI, {16'h0, FMT[47:32]}, `ESR_RESP_OKAY);
    axi_rd(`ESR_OFF_FMT_HI, {16'h0, FMT[47:32]}, `ESR_RESP_OKAY);
    run_rec(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
    run_rec(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
    run_rec(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
    axi_wr(`ESR_OFF_CTRL, 32'h3, `ESR_RESP_OKAY);
    run_rec(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hA);
    run_rec(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 4'h5);
    run_rec(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF);
    axi_rd(`ESR_OFF_DROP, 32'h6, `ESR_RESP_OKAY);
    axi_rd(`ESR_OFF_STATUS, 32'h0006_0000, `ESR_RESP_OKAY);
    close_out();
  end
endmodule
`default_nettype wire
